//--- tsy_params.svh
`ifndef TSY_PARAMS_SVH
`define TSY_PARAMS_SVH
// register offsets inside one timer's 32-byte window
`define TSY_OFF_CTL0 5'h00
`define TSY_OFF_CTL1 5'h04
`define TSY_OFF_IOC0 5'h08
`define TSY_OFF_CNT 5'h0C
`define TSY_OFF_CCR0 5'h10
// field positions
`define TSY_CTL0_RUN 7
`define TSY_CTL1_SYNC 7
`define TSY_IOC0_OLS_LSB 4
`define TSY_IOC0_CEN_LSB 8
// timer index of the q timer, timers in total
`define TSY_Q_IDX 3'h4
`define TSY_NUM_TMR 5
// mode field encodings
`define TSY_MODE_PWM 3'h4
`define TSY_MODE_FREE 3'h5
`define TSY_MODE_TRI 3'h7
// reset values
`define TSY_CNT_RST 16'hFFFF
`define TSY_CCR_RST 16'h0000
`define TSY_CTL_RST 3'h0
`define TSY_IO_RST 4'h0
`endif

//--- tsy_pkg.sv
package tsy_pkg;
	// count direction of the triangular counter
	typedef enum logic [1:0] {
		TSY_UP = 2'b01,
		TSY_DN = 2'b10
	} tsy_dir_t;
	typedef logic [15:0] tsy_word_t;
endpackage

//--- tsy_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tsy_tmr_if;
	import tsy_pkg::*;
	logic run;
	logic sync_en;
	logic tick;
	logic [2:0] mode;
	logic link_tick;
	logic link_restart;
	logic link_load;
	logic [2:0] link_mode;
	logic wr_ccr;
	logic [1:0] wr_ch;
	tsy_word_t wr_data;
	logic [3:0] cap;
	logic [3:0] cap_en;
	tsy_word_t cnt;
	tsy_word_t ccr [4];
	logic [3:0] wave;
	logic restart_out;
	logic load_out;
	modport unit (input run, sync_en, tick, mode, link_tick, link_restart, link_load,
		link_mode, wr_ccr, wr_ch, wr_data, cap, cap_en,
		output cnt, ccr, wave, restart_out, load_out);
	modport ctrl (output run, sync_en, tick, mode, link_tick, link_restart, link_load,
		link_mode, wr_ccr, wr_ch, wr_data, cap, cap_en,
		input cnt, ccr, wave, restart_out, load_out);
endinterface
`default_nettype wire

//--- tsy_timer_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsy_params.svh"
module tsy_timer_unit import tsy_pkg::*; #(
	parameter bit HAS_TRI = 1'b0
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	tsy_tmr_if.unit bus
);
	tsy_word_t cnt_ff, nxt_cnt;
	tsy_word_t act_ff [4];
	tsy_word_t ccr_ff [4];
	tsy_dir_t dir_ff, nxt_dir;
	logic [3:0] tog_ff, nxt_tog;
	logic [3:0] match, lvl;
	logic [2:0] em_raw;
	logic is_tri, is_pwm, is_free, tick, m0, bottom, reload_all;

	// slaves borrow the master's mode; triangle only on q and only unlinked
	assign em_raw = bus.sync_en ? bus.link_mode : bus.mode;
	assign is_tri = (em_raw == `TSY_MODE_TRI) && HAS_TRI && !bus.sync_en;
	assign is_pwm = (em_raw == `TSY_MODE_PWM);
	assign is_free = !is_pwm && !is_tri;
	assign tick = bus.run && (bus.sync_en ? bus.link_tick : bus.tick);
	assign m0 = tick && (cnt_ff == act_ff[0]);
	assign bottom = tick && is_tri && (dir_ff == TSY_DN) && (cnt_ff == 16'h0000);
	// load event handed to slaves: cpu write in ppg, channel-0 match otherwise
	assign bus.restart_out = m0 && is_pwm;
	assign bus.load_out = is_free ? bus.wr_ccr : m0;
	assign reload_all = bus.sync_en ? bus.link_load : (!is_free && m0);

	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_ch
			assign match[k] = tick && (cnt_ff == act_ff[k]);
			assign lvl[k] = bus.run && (cnt_ff < act_ff[k]);
			assign bus.ccr[k] = ccr_ff[k];
		end
	endgenerate

	// ch0: toggle, except a linked slave in pwm which outputs pwm
	assign bus.wave[0] = (is_pwm && bus.sync_en) ? lvl[0] : tog_ff[0];
	assign bus.wave[3:1] = is_free ? tog_ff[3:1] : lvl[3:1];
	assign bus.cnt = cnt_ff;

	// counter: held at all-ones while stopped so the first tick lands on zero
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_dir = dir_ff;
		if (!bus.run) begin
			nxt_cnt = `TSY_CNT_RST;
			nxt_dir = TSY_UP;
		end else if (tick) begin
			if (bus.sync_en) begin
				nxt_cnt = bus.link_restart ? 16'h0000 : cnt_ff + 16'h0001;
			end else if (is_pwm && m0) begin
				nxt_cnt = 16'h0000;
			end else if (is_tri && dir_ff == TSY_DN) begin
				if (cnt_ff == 16'h0000) begin
					nxt_dir = TSY_UP;
					nxt_cnt = 16'h0001;
				end else begin
					nxt_cnt = cnt_ff - 16'h0001;
				end
			end else if (is_tri && m0) begin
				nxt_dir = TSY_DN;
				nxt_cnt = cnt_ff - 16'h0001;
			end else begin
				nxt_cnt = cnt_ff + 16'h0001;
			end
		end
	end

	// output toggles per mode
	always_comb begin
		nxt_tog = tog_ff;
		if (!bus.run) begin
			nxt_tog = 4'h0;
		end else if (is_free) begin
			nxt_tog = tog_ff ^ match;
		end else if (is_tri) begin
			nxt_tog[0] = tog_ff[0] ^ ((m0 && dir_ff == TSY_UP) || bottom);
		end else begin
			nxt_tog[0] = tog_ff[0] ^ m0;
		end
	end

	// capture beats a same-cycle cpu write to the same buffer
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cnt_ff <= `TSY_CNT_RST;
			dir_ff <= TSY_UP;
			tog_ff <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				ccr_ff[i] <= `TSY_CCR_RST;
				act_ff[i] <= `TSY_CCR_RST;
			end
		end else begin
			cnt_ff <= nxt_cnt;
			dir_ff <= nxt_dir;
			tog_ff <= nxt_tog;
			for (int i = 0; i < 4; i++) begin
				if (bus.cap[i] && bus.cap_en[i] && bus.run) begin
					ccr_ff[i] <= cnt_ff;
				end else if (bus.wr_ccr && bus.wr_ch == 2'(i)) begin
					ccr_ff[i] <= bus.wr_data;
				end
				if (reload_all) begin
					act_ff[i] <= ccr_ff[i];
				end else if (is_free && !bus.sync_en && bus.wr_ccr && bus.wr_ch == 2'(i)) begin
					act_ff[i] <= bus.wr_data;
				end else if (!bus.run) begin
					// stopped: prime compares so a triangle never turns down from zero
					act_ff[i] <= ccr_ff[i];
				end
			end
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	a_cnt_start_zero:
		assert property (!bus.run ##1 (bus.run && tick && !bus.sync_en) |=> cnt_ff == 16'h0000)
		else $error("counter did not start from zero");
	a_ppg_write_load:
		assert property (bus.wr_ccr && is_free && !bus.sync_en && !reload_all
			|=> act_ff[$past(bus.wr_ch)] == $past(bus.wr_data))
		else $error("ppg write did not reach compare");
	a_pwm_reload:
		assert property (!bus.sync_en && is_pwm && m0 && !bus.wr_ccr
			|=> cnt_ff == 16'h0000 && act_ff[1] == $past(ccr_ff[1]))
		else $error("pwm period end missed restart or reload");
	a_tri_turn:
		assert property (is_tri && m0 && dir_ff == TSY_UP
			|=> dir_ff == TSY_DN && tog_ff[0] != $past(tog_ff[0]))
		else $error("triangle top did not turn and toggle");
	a_tri_lockout:
		assert property ((bus.sync_en || !HAS_TRI) |-> !is_tri)
		else $error("triangle mode while linked or on p timer");
	c_tri_bottom: cover property (bottom);
	c_slave_restart: cover property (bus.sync_en && bus.link_restart && tick);
endmodule
`default_nettype wire

//--- tsy_timer_sync_top.sv
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tsy_params.svh"
module tsy_timer_sync_top import tsy_pkg::*; #(
	parameter int DIV_W = 7
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	output logic [15:0] rd_data_o,
	input wire logic [3:0] q_capture_trigger_i,
	output logic [15:0] p_timer_output_pin_o,
	output logic [3:0] q_timer_output_pin_o
);
	// which timer feeds each timer, and which may be slaves
	localparam int MASTER_OF [`TSY_NUM_TMR] = '{0, 0, 2, 2, 2};
	localparam logic [4:0] IS_SLAVE = 5'h1A;

	logic [4:0] run_ff;
	logic [4:0] sync_ff;
	logic [2:0] ps_ff [`TSY_NUM_TMR];
	logic [2:0] mode_ff [`TSY_NUM_TMR];
	logic [3:0] oen_ff [`TSY_NUM_TMR];
	logic [3:0] ols_ff [`TSY_NUM_TMR];
	logic [3:0] cen_ff [`TSY_NUM_TMR];
	logic [3:0] pin_ff [`TSY_NUM_TMR];
	logic [DIV_W-1:0] div_ff;
	logic [15:0] rd_ff, nxt_rd;
	logic [3:0] cap_s1_ff, cap_s2_ff, cap_s3_ff;
	logic [3:0] cap_edge;
	tsy_word_t cnt_w [`TSY_NUM_TMR];
	tsy_word_t ccr_w [`TSY_NUM_TMR][4];
	logic [3:0] wave_w [`TSY_NUM_TMR];
	logic [4:0] tick_w;
	logic [4:0] sync_eff;

	// bus decode
	logic [2:0] sel_t;
	logic [4:0] reg_o;
	logic hit;
	logic wr_ctl0, wr_ctl1, wr_ioc0, wr_ccr;
	assign sel_t = addr_i[7:5];
	assign reg_o = addr_i[4:0];
	assign hit = (sel_t < 3'(`TSY_NUM_TMR)) && (addr_i[1:0] == 2'h0);
	assign wr_ctl0 = wr_en_i && hit && (reg_o == `TSY_OFF_CTL0);
	assign wr_ctl1 = wr_en_i && hit && (reg_o == `TSY_OFF_CTL1);
	assign wr_ioc0 = wr_en_i && hit && (reg_o == `TSY_OFF_IOC0);
	assign wr_ccr = wr_en_i && hit && addr_i[4];

	// prescaler select: 0 = every cycle, s = once per 2**s cycles
	function automatic logic presc_fire(input logic [2:0] sel, input logic [DIV_W-1:0] div);
		logic [DIV_W-1:0] mask;
		mask = DIV_W'((8'h01 << sel) - 8'h01);
		return (div & mask) == mask;
	endfunction

	// capture pins cross in from outside, two flops then an edge detect
	assign cap_edge = cap_s2_ff & ~cap_s3_ff;

	tsy_tmr_if tif [`TSY_NUM_TMR] ();

	genvar g;
	generate
		for (g = 0; g < `TSY_NUM_TMR; g++) begin : g_tmr
			// master bit is ignored so a master can never follow anybody
			assign sync_eff[g] = sync_ff[g] & IS_SLAVE[g];
			assign tick_w[g] = presc_fire(ps_ff[g], div_ff);
			assign tif[g].run = run_ff[g];
			assign tif[g].sync_en = sync_eff[g];
			assign tif[g].tick = tick_w[g];
			assign tif[g].mode = mode_ff[g];
			// link from the master: its tick, restart, load event and mode
			assign tif[g].link_tick = tick_w[MASTER_OF[g]] && run_ff[MASTER_OF[g]];
			assign tif[g].link_restart = tif[MASTER_OF[g]].restart_out;
			assign tif[g].link_load = tif[MASTER_OF[g]].load_out;
			assign tif[g].link_mode = mode_ff[MASTER_OF[g]];
			assign tif[g].wr_ccr = wr_ccr && (sel_t == 3'(g));
			assign tif[g].wr_ch = addr_i[3:2];
			assign tif[g].wr_data = wr_data_i;
			assign tif[g].cap = (g == `TSY_NUM_TMR - 1) ? cap_edge : 4'h0;
			assign tif[g].cap_en = cen_ff[g];
			assign cnt_w[g] = tif[g].cnt;
			assign wave_w[g] = tif[g].wave;
			for (genvar c = 0; c < 4; c++) begin : g_ccr
				assign ccr_w[g][c] = tif[g].ccr[c];
			end
			tsy_timer_unit #(
				.HAS_TRI(g == `TSY_NUM_TMR - 1)
			) u_tmr (
				.core_clk_i(core_clk_i),
				.srst_i(srst_i),
				.bus(tif[g])
			);
			// pin: level bit, flipped by the waveform only while enabled and running
			always_ff @(posedge core_clk_i) begin
				if (srst_i) begin
					pin_ff[g] <= `TSY_IO_RST;
				end else begin
					pin_ff[g] <= ols_ff[g] ^ (oen_ff[g] & {4{run_ff[g]}} & wave_w[g]);
				end
			end
		end
	endgenerate

	// control registers; fields keep their value across a running timer
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			run_ff <= 5'h00;
			sync_ff <= 5'h00;
			for (int t = 0; t < `TSY_NUM_TMR; t++) begin
				ps_ff[t] <= `TSY_CTL_RST;
				mode_ff[t] <= `TSY_CTL_RST;
				oen_ff[t] <= `TSY_IO_RST;
				ols_ff[t] <= `TSY_IO_RST;
				cen_ff[t] <= `TSY_IO_RST;
			end
		end else begin
			for (int t = 0; t < `TSY_NUM_TMR; t++) begin
				if (sel_t == 3'(t)) begin
					if (wr_ctl0) begin
						run_ff[t] <= wr_data_i[`TSY_CTL0_RUN];
						ps_ff[t] <= wr_data_i[2:0];
					end
					if (wr_ctl1) begin
						sync_ff[t] <= wr_data_i[`TSY_CTL1_SYNC];
						mode_ff[t] <= wr_data_i[2:0];
					end
					if (wr_ioc0) begin
						oen_ff[t] <= wr_data_i[3:0];
						ols_ff[t] <= wr_data_i[`TSY_IOC0_OLS_LSB +: 4];
						cen_ff[t] <= wr_data_i[`TSY_IOC0_CEN_LSB +: 4];
					end
				end
			end
		end
	end

	// read mux; unmapped or unaligned reads answer zero
	always_comb begin
		nxt_rd = 16'h0000;
		if (!rd_en_i || !hit) begin
			nxt_rd = 16'h0000;
		end else if (reg_o == `TSY_OFF_CTL0) begin
			nxt_rd = {8'h00, run_ff[sel_t], 4'h0, ps_ff[sel_t]};
		end else if (reg_o == `TSY_OFF_CTL1) begin
			nxt_rd = {8'h00, sync_ff[sel_t], 4'h0, mode_ff[sel_t]};
		end else if (reg_o == `TSY_OFF_IOC0) begin
			nxt_rd = {4'h0, cen_ff[sel_t], ols_ff[sel_t], oen_ff[sel_t]};
		end else if (reg_o == `TSY_OFF_CNT) begin
			nxt_rd = cnt_w[sel_t];
		end else if (addr_i[4]) begin
			nxt_rd = ccr_w[sel_t][addr_i[3:2]];
		end
	end

	// free-running prescaler, capture synchroniser and read data
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			div_ff <= '0;
			rd_ff <= 16'h0000;
			cap_s1_ff <= 4'h0;
			cap_s2_ff <= 4'h0;
			cap_s3_ff <= 4'h0;
		end else begin
			div_ff <= div_ff + DIV_W'(1);
			rd_ff <= nxt_rd;
			cap_s1_ff <= q_capture_trigger_i;
			cap_s2_ff <= cap_s1_ff;
			cap_s3_ff <= cap_s2_ff;
		end
	end

	assign rd_data_o = rd_ff;
	assign p_timer_output_pin_o = {pin_ff[3], pin_ff[2], pin_ff[1], pin_ff[0]};
	assign q_timer_output_pin_o = pin_ff[4];

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	a_pin_disabled_level:
		assert property (!oen_ff[4][0] |=> q_timer_output_pin_o[0] == $past(ols_ff[4][0]))
		else $error("disabled pin not at level bit");
	a_pin_idle_low:
		assert property (oen_ff[0][1] && !ols_ff[0][1] && !run_ff[0]
			|=> !p_timer_output_pin_o[1])
		else $error("stopped pin not low");
	a_pin_idle_high:
		assert property (oen_ff[4][2] && ols_ff[4][2] && !run_ff[4]
			|=> q_timer_output_pin_o[2])
		else $error("stopped inverted pin not high");
	a_pin_active_inv:
		assert property (oen_ff[4][1] && ols_ff[4][1] && run_ff[4] && wave_w[4][1]
			|=> !q_timer_output_pin_o[1])
		else $error("inverted pin not low when active");
	a_group_q_link:
		assert property (sync_eff[4] |-> tif[4].link_tick == (tick_w[2] && run_ff[2]))
		else $error("q timer not fed by master p2");
	a_master_never_linked:
		assert property (sync_eff[0] == 1'b0 && sync_eff[2] == 1'b0)
		else $error("master timer linked");
	a_slave_aligned:
		assert property (sync_eff[1] && run_ff[1] && run_ff[0] && tif[0].restart_out
			|=> cnt_w[1] == 16'h0000 && cnt_w[0] == 16'h0000)
		else $error("slave p1 not restarted with master");
	a_read_zero_unmapped:
		assert property (rd_en_i && !hit |=> rd_data_o == 16'h0000)
		else $error("unmapped read not zero");
	c_linked_pair_run: cover property (sync_eff[3] && run_ff[3] ##1 run_ff[2]);
	c_q_capture: cover property (cap_edge != 4'h0 && run_ff[4]);
	c_pin_toggle: cover property (q_timer_output_pin_o[0] != $past(q_timer_output_pin_o[0]));
endmodule
`default_nettype wire

//--- tsy_cap_src.sv
`timescale 1ns/1ps
`default_nettype none
// far-side capture pin source for the q timer
module tsy_cap_src (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic fire_i,
	output logic [3:0] trig_o
);
	logic [2:0] hold_ff;
	// hold the pins high a few clocks so the 2-flop sync cannot miss them
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			hold_ff <= 3'h0;
		end else if (fire_i) begin
			hold_ff <= 3'h4;
		end else if (hold_ff != 3'h0) begin
			hold_ff <= hold_ff - 3'h1;
		end
	end
	// released pins drop to their idle low level
	assign trig_o = {4{hold_ff != 3'h0}};
endmodule
`default_nettype wire

//--- tsy_timer_sync_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsy_params.svh"
module tsy_timer_sync_top_tb;
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdat = 16'h0000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic fire = 1'b0;
	logic [15:0] rd_data;
	logic [3:0] trig;
	logic [15:0] p_pins;
	logic [3:0] q_pins;
	logic [3:0] lvl [5];
	logic [15:0] a_v;
	logic [15:0] b_v;
	logic st;
	int err_total = 0;
	int cmp_count = 0;
	int seed = 76193;
	int n;
	int ord [5] = '{1, 3, 4, 0, 2};
	// 50 MHz core clock
	always #10 core_clk_i = ~core_clk_i;
	tsy_timer_sync_top #(.DIV_W(7)) i_tsy_timer_sync_top (.core_clk_i(core_clk_i),
		.srst_i(srst_i), .addr_i(addr), .wr_data_i(wdat), .wr_en_i(wr_en), .rd_en_i(rd_en),
		.rd_data_o(rd_data), .q_capture_trigger_i(trig), .p_timer_output_pin_o(p_pins),
		.q_timer_output_pin_o(q_pins));
	tsy_cap_src i_tsy_cap_src (.core_clk_i(core_clk_i), .srst_i(srst_i), .fire_i(fire),
		.trig_o(trig));
	function automatic logic [7:0] ra(input int t, input int off);
		return {t[2:0], off[4:0]};
	endfunction
	function automatic logic [3:0] nib(input int t);
		return (t < 4) ? p_pins[4*t +: 4] : q_pins;
	endfunction
	task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_pin(input string nm, input logic [3:0] e, input logic [3:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic do_reset();
		@(posedge core_clk_i);
		srst_i <= 1'b1;
		repeat (8) @(posedge core_clk_i);
		srst_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		wr_en <= 1'b1;
		addr <= a;
		wdat <= d;
		@(posedge core_clk_i);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge core_clk_i);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge core_clk_i);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask
	// two reads back to back, so the second sees one clock later
	task automatic rd2(input logic [7:0] a, input logic [7:0] b, output logic [15:0] da,
		output logic [15:0] db);
		@(posedge core_clk_i);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge core_clk_i);
		addr <= b;
		#1 da = rd_data;
		@(posedge core_clk_i);
		rd_en <= 1'b0;
		#1 db = rd_data;
	endtask
	// counts changes of pin b, and whether pin s never moved
	task automatic watch(input int b, input int s, input int cyc, output int tg, output logic sv);
		logic [19:0] pv;
		logic [19:0] cv;
		#1 pv = {q_pins, p_pins};
		tg = 0;
		sv = 1'b1;
		repeat (cyc) begin
			@(posedge core_clk_i);
			#1 cv = {q_pins, p_pins};
			if (cv[b] !== pv[b]) tg++;
			if (cv[s] !== pv[s]) sv = 1'b0;
			pv = cv;
		end
	endtask
	// hang guard
	initial begin
		#1000000;
		err_total++;
		summarize();
	end
	// main sequence
	initial begin
		do_reset();
		for (int t = 0; t < 5; t++) begin
			rd(ra(t, `TSY_OFF_CNT), a_v);
			chk_word("count at reset", 16'hFFFF, a_v);
		end
		rd(8'hA0, a_v);
		chk_word("unmapped read", 16'h0000, a_v);
		wr(ra(0, `TSY_OFF_CNT), 16'h1234);
		rd(ra(0, `TSY_OFF_CNT), a_v);
		chk_word("count read-only", 16'hFFFF, a_v);
		// disabled outputs follow the level bit whatever the run bit
		for (int t = 0; t < 5; t++) begin
			a_v = 16'($random(seed));
			wr(ra(t, `TSY_OFF_IOC0), {8'h00, a_v[3:0], 4'h0});
			wr(ra(t, `TSY_OFF_CTL0), {8'h00, a_v[4], 7'h00});
			rd(ra(t, `TSY_OFF_IOC0), b_v);
			chk_word("io control readback", {8'h00, a_v[3:0], 4'h0}, b_v);
			repeat (3) @(posedge core_clk_i);
			#1 chk_pin("disabled pins", a_v[3:0], nib(t));
		end
		// free-running, enabled: level while stopped, one toggle soon after start
		do_reset();
		for (int t = 0; t < 5; t++) begin
			lvl[t] = 4'($random(seed));
			wr(ra(t, `TSY_OFF_CTL1), 16'h0005);
			for (int k = 0; k < 4; k++) wr(ra(t, `TSY_OFF_CCR0 + 4 * k), k[15:0]);
			wr(ra(t, `TSY_OFF_IOC0), {8'h00, lvl[t], 4'hF});
		end
		repeat (3) @(posedge core_clk_i);
		#1;
		for (int t = 0; t < 5; t++) chk_pin("stopped pins", lvl[t], nib(t));
		for (int t = 0; t < 5; t++) wr(ra(t, `TSY_OFF_CTL0), 16'h0080);
		repeat (14) @(posedge core_clk_i);
		#1;
		for (int t = 0; t < 5; t++) chk_pin("running pins", ~lvl[t], nib(t));
		// linked slaves slow on their own, count with the master instead
		do_reset();
		for (int i = 0; i < 5; i++) begin
			wr(ra(ord[i], `TSY_OFF_CTL1), 16'h0085);
			wr(ra(ord[i], `TSY_OFF_CTL0), 16'h0007);
		end
		for (int i = 0; i < 3; i++) wr(ra(ord[i], `TSY_OFF_CTL0), 16'h0087);
		wr(ra(0, `TSY_OFF_CTL0), 16'h0080);
		wr(ra(2, `TSY_OFF_CTL0), 16'h0080);
		repeat (4) @(posedge core_clk_i);
		for (int i = 0; i < 3; i++) begin
			rd2(ra((i == 0) ? 0 : 2, `TSY_OFF_CNT), ra(ord[i], `TSY_OFF_CNT), a_v, b_v);
			chk_word("slave count", a_v + 16'h0001, b_v);
		end
		rd2(ra(0, `TSY_OFF_CNT), ra(0, `TSY_OFF_CNT), a_v, b_v);
		chk_word("master ignores own sync bit", a_v + 16'h0001, b_v);
		// linked p1 in ppg use: its own compare write waits for a master write
		rd(ra(1, `TSY_OFF_CNT), a_v);
		wr(ra(1, `TSY_OFF_IOC0), 16'h0001);
		wr(ra(1, `TSY_OFF_CCR0), a_v + 16'h0018);
		repeat (30) @(posedge core_clk_i);
		#1 chk_pin("slave compare held", 4'h1, nib(1));
		rd(ra(1, `TSY_OFF_CNT), a_v);
		wr(ra(1, `TSY_OFF_CCR0), a_v + 16'h0018);
		wr(ra(0, `TSY_OFF_CCR0 + 4), 16'h0000);
		repeat (30) @(posedge core_clk_i);
		#1 chk_pin("slave compare moved at master write", 4'h0, nib(1));
		// pwm master p2 with linked slave p3
		do_reset();
		wr(ra(3, `TSY_OFF_CTL1), 16'h0085);
		wr(ra(3, `TSY_OFF_CCR0), 16'hFFFF);
		wr(ra(3, `TSY_OFF_IOC0), 16'h000F);
		wr(ra(2, `TSY_OFF_CTL1), 16'h0004);
		wr(ra(2, `TSY_OFF_CCR0), 16'h0005);
		wr(ra(2, `TSY_OFF_IOC0), 16'h000F);
		wr(ra(3, `TSY_OFF_CTL0), 16'h0080);
		wr(ra(2, `TSY_OFF_CTL0), 16'h0080);
		repeat (20) @(posedge core_clk_i);
		watch(8, 12, 24, n, st);
		chk_word("master ch0 toggles", 16'h0004, n[15:0]);
		chk_pin("linked slave ch0 pwm", 4'h3, {2'h0, st, p_pins[12]});
		rd(ra(2, `TSY_OFF_CNT), a_v);
		chk_word("pwm count in period", 16'h0001, {15'h0000, a_v <= 16'h0005});
		wr(ra(3, `TSY_OFF_CCR0), 16'h0000);
		repeat (20) @(posedge core_clk_i);
		watch(8, 12, 8, n, st);
		chk_pin("slave compare moved at match", 4'h2, {2'h0, st, p_pins[12]});
		// triangle pwm on the unlinked q timer
		do_reset();
		wr(ra(4, `TSY_OFF_CTL1), 16'h0007);
		wr(ra(4, `TSY_OFF_CCR0), 16'h0004);
		wr(ra(4, `TSY_OFF_CCR0 + 4), 16'hFFFF);
		wr(ra(4, `TSY_OFF_IOC0), 16'h000F);
		wr(ra(4, `TSY_OFF_CTL0), 16'h0080);
		repeat (10) @(posedge core_clk_i);
		watch(16, 17, 40, n, st);
		chk_word("triangle ch0 toggles", 16'h0001, {15'h0000, n >= 8 && n <= 12});
		chk_pin("triangle ch1", 4'h3, {2'h0, st, q_pins[1]});
		// capture right after a slow start
		do_reset();
		wr(ra(4, `TSY_OFF_IOC0), 16'h0F00);
		wr(ra(4, `TSY_OFF_CTL0), 16'h0087);
		@(posedge core_clk_i);
		fire <= 1'b1;
		@(posedge core_clk_i);
		fire <= 1'b0;
		repeat (8) @(posedge core_clk_i);
		for (int k = 0; k < 4; k++) begin
			rd(ra(4, `TSY_OFF_CCR0 + 4 * k), a_v);
			chk_word("early capture", 16'h0001, {15'h0000, a_v === 16'hFFFF || a_v === 16'h0000});
		end
		@(posedge core_clk_i);
		#1 chk_word("read data idle", 16'h0000, rd_data);
		summarize();
	end
endmodule
`default_nettype wire
